// ==== logic/mcb4_defines.vh ====
// Constants for the bank 4 machine-check status logging block.
`ifndef MCB4_DEFINES_VH
`define MCB4_DEFINES_VH
`define MCB4_OFF_STATUS_LO 12'h000
`define MCB4_OFF_STATUS_HI 12'h004
`define MCB4_OFF_CTRL 12'h008
`define MCB4_OFF_COUNT 12'h00C
`define MCB4_CODE_INTERNAL 16'h0400
`define MCB4_CODE_TAG 16'h010B
`define MCB4_CODE_BUS 16'h0E0F
`define MCB4_TYPE_INTERNAL 2'h0
`define MCB4_TYPE_TAG 2'h1
`define MCB4_TYPE_BUS 2'h2
`define MCB4_THR_NONE 2'h0
`define MCB4_THR_RSVD 2'h3
`define MCB4_CNT_MAX 8'hFF
`define MCB4_CNT_RESET 8'h00
`define MCB4_CTRL_RESET 32'h00000001
`define MCB4_HI_CNT_LSB 0
`define MCB4_HI_FMT_LSB 8
`define MCB4_HI_SYN_LSB 12
`define MCB4_HI_SYNV_BIT 20
`define MCB4_HI_THR_LSB 21
`define MCB4_HI_PCC_BIT 25
`define MCB4_HI_ADDRV_BIT 26
`define MCB4_HI_EXTRA_INFO_VALID_BIT 27
`define MCB4_HI_EN_BIT 28
`define MCB4_HI_UC_BIT 29
`define MCB4_HI_OVER_BIT 30
`define MCB4_HI_VAL_BIT 31
`define MCB4_HI_FLAG_LSB 25
`endif

// ==== logic/mcb4_type_encoder.v ====
// Maps an error type select onto its 16-bit error type code.
`include "mcb4_defines.vh"
module mcb4_type_encoder (
  input wire [1:0] type_sel,
  output reg [15:0] type_code,
  output reg type_legal
);
  always @* begin
    type_code = `MCB4_CODE_INTERNAL;
    type_legal = 1'b1;
    case (type_sel)
      `MCB4_TYPE_INTERNAL: type_code = `MCB4_CODE_INTERNAL;
      `MCB4_TYPE_TAG: type_code = `MCB4_CODE_TAG;
      `MCB4_TYPE_BUS: type_code = `MCB4_CODE_BUS;
      default: type_legal = 1'b0;
    endcase
  end
endmodule

// ==== logic/mcb4_ce_counter.v ====
// Saturating counter of correctable events, cleared by cold reset only.
`include "mcb4_defines.vh"
module mcb4_ce_counter (
  input wire core_clk,
  input wire rst,
  input wire count_en,
  output wire [7:0] count
);
  reg [7:0] count_reg;
  always @(posedge core_clk) begin
    if (rst) begin
      count_reg <= `MCB4_CNT_RESET;
    end else if (count_en && count_reg != `MCB4_CNT_MAX) begin
      count_reg <= count_reg + 8'h01;
    end
  end
  assign count = count_reg;
endmodule

// ==== logic/mcb4_status_log.v ====
// Bank 4 machine-check status logger with an APB register slave.
//
// Behaviour
// - Internal controller error logs type code 0x0400 in bits 15:0.
// - Cache tag error logs type code 0x010B in bits 15:0.
// - Bus or interconnect error logs type code 0x0E0F in bits 15:0.
// - Reserved bus-class codes are never produced.
// - Type field only ever holds one of the three defined codes.
// - Detailed model-specific code goes into bits 31:16.
// - Bits 56:32 share one layout for all three error types.
// - Bits 39:32 count correctable events; only cold reset clears them.
// - Count reads 1 after first event, saturates at 255.
// - Bits 41:40 give the extra-info format, meaningful with its valid flag.
// - Bits 51:44 hold the ECC syndrome of a correctable event.
// - Bit 52 set only when the correctable event supplied a syndrome.
// - Bits 54:53 give threshold health; 11 is never stored.
// - Threshold field valid only while bit 63 is set.
// - Threshold field undefined while bit 61 is set.
// - Bit 63 set on logging; software clears it.
`include "mcb4_defines.vh"
module mcb4_status_log (
  input wire core_clk,
  input wire rst,
  input wire warm_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  input wire err_valid,
  input wire [1:0] err_type,
  input wire [15:0] err_model_code,
  input wire err_uncorrected,
  input wire err_context_corrupt,
  input wire err_addr_valid,
  input wire err_extra_valid,
  input wire err_enabled,
  input wire [1:0] err_extra_format,
  input wire err_syndrome_valid,
  input wire [7:0] err_syndrome,
  input wire [1:0] err_threshold,
  output wire [63:0] error_bank4_status
);
  reg [15:0] type_reg;
  reg [15:0] model_reg;
  reg [1:0] fmt_reg;
  reg [7:0] syn_reg;
  reg synv_reg;
  reg [1:0] thr_reg;
  reg [6:0] flags_reg;
  reg log_en_reg;
  wire [15:0] enc_code;
  wire enc_legal;
  wire [7:0] ce_count;
  wire [31:0] status_hi;
  wire [31:0] status_lo;
  wire old_val;
  wire old_uc;
  wire old_en;
  wire take_event;
  wire keep_old;
  wire do_log;
  wire ce_event;
  wire setup;
  wire wr_access;
  wire [1:0] thr_clean;

  mcb4_type_encoder u_enc (
    .type_sel(err_type),
    .type_code(enc_code),
    .type_legal(enc_legal)
  );

  // Correctable events are counted even when the record is not replaced.
  assign ce_event = err_valid && enc_legal && !err_uncorrected;

  mcb4_ce_counter u_cnt (
    .core_clk(core_clk),
    .rst(rst),
    .count_en(ce_event),
    .count(ce_count)
  );

  assign old_val = flags_reg[6];
  assign old_uc = flags_reg[4];
  assign old_en = flags_reg[3];
  assign take_event = err_valid && enc_legal && log_en_reg;
  // Uncorrected beats corrected, enabled beats disabled, old UC stays.
  assign keep_old = old_val && ((old_uc) ||
                    (old_en && !err_enabled && !err_uncorrected));
  assign do_log = take_event && !keep_old;
  // The reserved threshold code is never stored.
  assign thr_clean = (err_threshold == `MCB4_THR_RSVD) ?
                     `MCB4_THR_NONE : err_threshold;

  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign pready = 1'b1;

  always @(posedge core_clk) begin
    if (rst || warm_rst) begin
      log_en_reg <= 1'b1;
    end else if (wr_access && paddr == `MCB4_OFF_CTRL) begin
      log_en_reg <= pwdata[0];
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      type_reg <= `MCB4_CODE_INTERNAL;
      model_reg <= 16'h0000;
      fmt_reg <= 2'h0;
      syn_reg <= 8'h00;
      synv_reg <= 1'b0;
      thr_reg <= `MCB4_THR_NONE;
      flags_reg <= 7'h00;
    end else begin
      if (wr_access && paddr == `MCB4_OFF_STATUS_HI) begin
        flags_reg <= pwdata[31:`MCB4_HI_FLAG_LSB];
      end
      if (take_event && old_val) begin
        flags_reg[5] <= 1'b1;
      end
      if (do_log) begin
        type_reg <= enc_code;
        model_reg <= err_model_code;
        fmt_reg <= err_extra_valid ? err_extra_format : 2'h0;
        syn_reg <= (err_syndrome_valid && !err_uncorrected) ?
                   err_syndrome : 8'h00;
        synv_reg <= err_syndrome_valid && !err_uncorrected;
        thr_reg <= thr_clean;
        flags_reg[0] <= err_context_corrupt || err_uncorrected;
        flags_reg[1] <= err_addr_valid;
        flags_reg[2] <= err_extra_valid;
        flags_reg[3] <= err_enabled;
        flags_reg[4] <= err_uncorrected;
        flags_reg[5] <= old_val;
        flags_reg[6] <= 1'b1;
      end
    end
  end

  assign status_lo = {model_reg, type_reg};
  // Common layout for every type; reserved positions are constant zero.
  assign status_hi = {flags_reg, 2'b00, thr_reg, synv_reg, syn_reg,
                      2'b00, fmt_reg, ce_count};
  assign error_bank4_status = {status_hi, status_lo};

  always @(posedge core_clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= 1'b0;
      case (paddr)
        `MCB4_OFF_STATUS_LO: prdata <= status_lo;
        `MCB4_OFF_STATUS_HI: prdata <= status_hi;
        `MCB4_OFF_CTRL: prdata <= {31'h00000000, log_en_reg};
        `MCB4_OFF_COUNT: prdata <= {24'h000000, ce_count};
        default: begin
          prdata <= 32'h00000000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end
endmodule

// ==== verif/mcb4_status_log_checker.sv ====
// Port assertions for the bank 4 status logger.
module mcb4_status_log_checker (
  input wire core_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire err_valid,
  input wire [1:0] err_type,
  input wire err_uncorrected,
  input wire [63:0] error_bank4_status
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire [15:0] code = error_bank4_status[15:0];
  wire [7:0] cnt = error_bank4_status[39:32];
  wire ce = err_valid && err_type != 2'h3 && !err_uncorrected;
  type_legal_a: assert property (
    code == 16'h0400 || code == 16'h010B || code == 16'h0E0F)
    else $error("type code outside the defined set");
  no_reserved_a: assert property (
    !(code[7:0] == 8'h0F && code[15:8] inside {[8'h08:8'h0D], 8'h0F}))
    else $error("reserved bus class code");
  rsvd_zero_a: assert property (
    error_bank4_status[43:42] == 2'h0 && error_bank4_status[56:55] == 2'h0)
    else $error("reserved bits not zero");
  thr_legal_a: assert property (
    error_bank4_status[54:53] != 2'h3) else $error("threshold reserved");
  syn_corr_a: assert property (
    error_bank4_status[52] |-> !error_bank4_status[61])
    else $error("syndrome valid on uncorrected record");
  cnt_step_a: assert property (
    ce |=> cnt == ($past(cnt) == 8'hFF ? 8'hFF : $past(cnt) + 8'h01))
    else $error("counter step wrong");
  cnt_hold_a: assert property (
    !ce |=> $stable(cnt)) else $error("counter moved without event");
  val_cause_a: assert property (
    $rose(error_bank4_status[63]) |-> $past(err_valid && err_type != 2'h3 ||
    psel && penable && pwrite && paddr == 12'h004 && pwdata[31]))
    else $error("valid flag set without cause");
endmodule
bind mcb4_status_log mcb4_status_log_checker checker_inst (.*);

// ==== verif/mcb4_status_log_test.sv ====
// Self-checking bench for the bank 4 status logger.
module mcb4_status_log_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst = 1, warm_rst = 0, psel = 0, penable = 0;
  logic pwrite = 0, pready, pslverr, perr, err_valid = 0;
  logic err_uncorrected = 0, err_context_corrupt = 0, err_addr_valid = 0;
  logic err_extra_valid = 0, err_enabled = 0, err_syndrome_valid = 0;
  logic [1:0] err_type = 0, err_extra_format = 0, err_threshold = 0;
  logic [11:0] paddr = 0;
  logic [15:0] err_model_code = 0;
  logic [7:0] err_syndrome = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [63:0] error_bank4_status, exp;
  int mismatches = 0, samples_checked = 0, seed = 32'h21974b56, cnt = 0;
  mcb4_status_log mcb4_status_log_inst (.*);
  initial forever #2.5 core_clk = ~core_clk;
  task chk(input logic [63:0] a, input logic [63:0] b);
    samples_checked++;
    if (a !== b) begin
      mismatches++;
      $display("FAIL %0t got %h exp %h", $time, a, b);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
    if (w && a == 12'h004) exp[63:57] = d[31:25];
  endtask
  task ev(input logic [1:0] t, input logic uc);
    logic [31:0] r, f;
    logic sv;
    apb(1, 12'h004, 32'h0);
    r = $random(seed);
    f = $random(seed);
    sv = f[0] & !uc;
    @(posedge core_clk);
    {err_model_code, err_extra_format, err_threshold} <= {r[27:12], r[3:0]};
    err_syndrome <= r[11:4] & {8{f[0]}};
    {err_context_corrupt, err_addr_valid, err_extra_valid} <= f[4:2];
    {err_enabled, err_syndrome_valid} <= f[1:0];
    {err_valid, err_type, err_uncorrected} <= {1'b1, t, uc};
    if (t != 2'h3) begin
      if (!uc && cnt < 255) cnt++;
      exp[31:0] = {r[27:12], t == 0 ? 16'h0400 : t == 1 ? 16'h010B : 16'h0E0F};
      exp[63:32] = {2'b10, uc, f[1], f[2], f[3], f[4] | uc, 2'b00,
        r[1:0] == 2'h3 ? 2'h0 : r[1:0], sv, sv ? r[11:4] : 8'h00, 2'b00,
        f[2] ? r[3:2] : 2'h0, cnt[7:0]};
    end
    @(posedge core_clk);
    err_valid <= 0;
    @(posedge core_clk);
    chk(error_bank4_status, exp);
    apb(0, 12'h000, 32'h0);
    chk({32'h0, rd}, {32'h0, exp[31:0]});
  endtask
  task end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    end_of_test;
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 0;
    exp = 64'h400;
    @(posedge core_clk);
    chk(error_bank4_status, exp);
    for (int i = 0; i < 16; i++) ev(i[1:0], i[2]);
    $display("event logging test done");
    apb(1, 12'h000, 32'hFFFFFFFF);
    apb(0, 12'h000, 32'h0);
    chk({32'h0, rd}, {32'h0, exp[31:0]});
    apb(0, 12'h010, 32'h0);
    chk({63'h0, perr}, 64'h1);
    $display("register access test done");
    apb(1, 12'h004, 32'h0);
    apb(1, 12'h008, 32'h0);
    @(posedge core_clk);
    {err_valid, err_type, err_uncorrected} <= 4'b1100;
    @(posedge core_clk);
    err_valid <= 0;
    if (cnt < 255) cnt++;
    exp[39:32] = cnt[7:0];
    @(posedge core_clk);
    chk(error_bank4_status, exp);
    warm_rst <= 1;
    @(posedge core_clk);
    warm_rst <= 0;
    apb(0, 12'h008, 32'h0);
    chk({32'h0, rd}, 64'h1);
    chk(error_bank4_status, exp);
    ev(2'h2, 1'b1);
    @(posedge core_clk);
    {err_valid, err_type, err_uncorrected} <= 4'b1010;
    @(posedge core_clk);
    err_valid <= 0;
    if (cnt < 255) cnt++;
    exp[39:32] = cnt[7:0];
    exp[62] = 1'b1;
    @(posedge core_clk);
    chk(error_bank4_status, exp);
    $display("logging control test done");
    @(posedge core_clk);
    {err_valid, err_type, err_uncorrected} <= 4'b1010;
    repeat (256) @(posedge core_clk);
    err_valid <= 0;
    warm_rst <= 1;
    @(posedge core_clk);
    warm_rst <= 0;
    apb(0, 12'h00C, 32'h0);
    chk({32'h0, rd}, 64'hFF);
    $display("counter saturation test done");
    end_of_test;
  end
endmodule
